// ### logic/ssrc_pkg.sv
// shared constants for the slot repeat-count sequencer
package ssrc_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam int          NUM_SLOTS      = 8;
    localparam int          SLOT_IDX_W     = 3;
    localparam int          REP_W          = 2;
    localparam int          VAL_W          = 7;
    localparam int          LOOP_W         = 3;
    // register offsets
    localparam logic [7:0]  CTRL_OFS       = 8'h0C;
    localparam logic [7:0]  SLOT_FIRST_OFS = 8'h0F;
    localparam logic [7:0]  SLOT_LAST_OFS  = 8'h16;
    localparam logic [7:0]  REP_LOWER_OFS  = 8'h17;
    localparam logic [7:0]  REP_UPPER_OFS  = 8'h18;
    localparam logic [7:0]  MAIN_LOOP_OFS  = 8'h19;
    // field positions
    localparam int          CTRL_GO_BIT    = 0;
    localparam int          DELAY_FLAG_BIT = 7;
    // reset values
    localparam logic [7:0]  REP_RST        = 8'h00;
    localparam logic [7:0]  SLOT_RST       = 8'h00;
    localparam logic [2:0]  LOOP_RST       = 3'h0;
    // loop count that means run until stopped
    localparam logic [2:0]  LOOP_FOREVER   = 3'h7;
    localparam logic [2:0]  LAST_SLOT      = 3'h7;
    // timing
    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          DELAY_UNIT_MS  = 10;
    localparam int          DELAY_UNIT_CYC =
        DELAY_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [4:0] {
        SEQ_IDLE  = 5'b00001,
        SEQ_CHECK = 5'b00010,
        SEQ_PLAY  = 5'b00100,
        SEQ_WAIT  = 5'b01000,
        SEQ_NEXT  = 5'b10000
    } ssrc_state_e;
endpackage : ssrc_pkg

// ### logic/ssrc_delay_timer.sv
// timed idle of units times a fixed tick length
module ssrc_delay_timer #(
    parameter int UNIT_CYC = ssrc_pkg::DELAY_UNIT_CYC
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    rstn_i,
    input  wire logic                    start_i,
    input  wire logic                    abort_i,
    input  wire logic [ssrc_pkg::VAL_W-1:0] units_i,
    output logic                         done_o
);
    import ssrc_pkg::*;

    localparam int TW = $clog2(UNIT_CYC + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(UNIT_CYC - 1);

    logic             run_q;
    logic [TW-1:0]    tick_q;
    logic [VAL_W-1:0] left_q;
    logic             done_q;

    wire unit_end = (tick_q == TICK_LAST);
    wire finish   = run_q && (left_q == '0);

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i || abort_i)
        begin
            run_q  <= 1'b0;
            tick_q <= '0;
            left_q <= '0;
            done_q <= 1'b0;
        end
        else if (start_i)
        begin
            run_q  <= 1'b1;
            tick_q <= '0;
            left_q <= units_i;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= finish;
            if (finish)
                run_q <= 1'b0;
            if (run_q && !finish)
                tick_q <= unit_end ? '0 : tick_q + TW'(1);
            if (run_q && !finish && unit_end)
                left_q <= left_q - VAL_W'(1);
        end
    end

    assign done_o = done_q;
endmodule : ssrc_delay_timer

// ### logic/ssrc_play_counter.sv
// counts plays of the current slot against its repeat field
module ssrc_play_counter (
    input  wire logic                    core_clk_i,
    input  wire logic                    rstn_i,
    input  wire logic                    clr_i,
    input  wire logic                    inc_i,
    input  wire logic [ssrc_pkg::REP_W-1:0] limit_i,
    output logic                         last_o
);
    import ssrc_pkg::*;

    logic [REP_W-1:0] cnt_q;

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i || clr_i)
            cnt_q <= '0;
        else if (inc_i)
            cnt_q <= cnt_q + REP_W'(1);
    end

    // extra plays done equals the programmed repeat value
    assign last_o = (cnt_q == limit_i);
endmodule : ssrc_play_counter

// ### logic/ssrc_sequencer.sv
// eight-slot sequencer with per-slot repeat counts and registers
// Summary of operation
// - repeat zero plays slot once, then advances
// - repeat N plays slot N plus one times
// - advance only after all plays complete
// - lower register holds slots one to four
// - upper register holds slots five to eight
// - repeat covers delay flag and value together
// - repeat fields read/write, reset to zero
// - delay flag means value times 10 ms idle
// - start slot one, stop at zero or eighth
// - main loop count replays whole sequence; 7 forever
//
// The implementer's own choice: the address-and-strobe port.
module ssrc_sequencer #(
    parameter int UNIT_CYC = ssrc_pkg::DELAY_UNIT_CYC
) (
    input  wire logic                       core_clk_i,
    input  wire logic                       rstn_i,
    input  wire logic [ssrc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [ssrc_pkg::DATA_W-1:0] wr_data_i,
    input  wire logic                       wr_en_i,
    input  wire logic                       rd_en_i,
    output logic      [ssrc_pkg::DATA_W-1:0] rd_data_o,
    input  wire logic                       stop_i,
    input  wire logic                       play_done_i,
    output logic                            play_req_o,
    output logic      [ssrc_pkg::VAL_W-1:0]  effect_id_o,
    output logic      [ssrc_pkg::SLOT_IDX_W-1:0] slot_idx_o,
    output logic                            delay_active_o,
    output logic                            busy_o,
    output logic                            seq_done_o
);
    import ssrc_pkg::*;

    logic [DATA_W-1:0]     rep_lower_q;
    logic [DATA_W-1:0]     rep_upper_q;
    logic [LOOP_W-1:0]     loop_q;
    logic [DATA_W-1:0]     slot_q [NUM_SLOTS];
    ssrc_state_e           state_q;
    ssrc_state_e           state_d;
    logic [SLOT_IDX_W-1:0] slot_idx_q;
    logic [SLOT_IDX_W-1:0] slot_idx_d;
    logic [LOOP_W-1:0]     pass_q;
    logic [LOOP_W-1:0]     pass_d;
    logic                  play_req_q;
    logic                  play_req_d;
    logic [VAL_W-1:0]      effect_id_q;
    logic                  busy_q;
    logic                  delay_active_q;
    logic                  seq_done_q;
    logic                  seq_done_d;
    logic [DATA_W-1:0]     rd_data_q;
    logic                  tmr_start;
    logic                  cnt_clr;
    logic                  cnt_inc;
    logic                  tmr_done;
    logic                  cnt_last;
    logic [REP_W-1:0]      rep_field [NUM_SLOTS];
    logic [DATA_W-1:0]     slot_rd [NUM_SLOTS];

    // register decode
    wire hit_ctrl  = (addr_i == CTRL_OFS);
    wire hit_lower = (addr_i == REP_LOWER_OFS);
    wire hit_upper = (addr_i == REP_UPPER_OFS);
    wire hit_loop  = (addr_i == MAIN_LOOP_OFS);
    wire hit_slot  = (addr_i >= SLOT_FIRST_OFS)
                  && (addr_i <= SLOT_LAST_OFS);
    wire [ADDR_W-1:0] slot_ofs = addr_i - SLOT_FIRST_OFS;
    wire [SLOT_IDX_W-1:0] slot_sel = slot_ofs[SLOT_IDX_W-1:0];

    wire go_wr   = wr_en_i && hit_ctrl && wr_data_i[CTRL_GO_BIT];
    // a stop from software or trigger beats any pending start
    wire stop_rq = stop_i
                || (wr_en_i && hit_ctrl && !wr_data_i[CTRL_GO_BIT]);

    wire [2*DATA_W-1:0] rep_all = {rep_upper_q, rep_lower_q};

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++)
        begin : g_slot
            // field g taken from bits 2g+1..2g, slot three at 5-4
            assign rep_field[g] = rep_all[REP_W*g +: REP_W];
            assign slot_rd[g]   = slot_q[g];

            always_ff @(posedge core_clk_i)
            begin
                if (!rstn_i)
                    slot_q[g] <= SLOT_RST;
                else if (wr_en_i && hit_slot
                         && slot_sel == SLOT_IDX_W'(g))
                    slot_q[g] <= wr_data_i;
            end
        end
    endgenerate

    // repeat registers read/write, zero after reset
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            rep_lower_q <= REP_RST;
            rep_upper_q <= REP_RST;
            loop_q      <= LOOP_RST;
        end
        else if (wr_en_i)
        begin
            if (hit_lower)
                rep_lower_q <= wr_data_i;
            if (hit_upper)
                rep_upper_q <= wr_data_i;
            if (hit_loop)
                loop_q <= wr_data_i[LOOP_W-1:0];
        end
    end

    // unmapped offsets and reserved bits read as zero
    wire [DATA_W-1:0] rd_mux =
        hit_slot  ? slot_rd[slot_sel] :
        hit_lower ? rep_lower_q :
        hit_upper ? rep_upper_q :
        hit_loop  ? {{(DATA_W-LOOP_W){1'b0}}, loop_q} :
        hit_ctrl  ? {{(DATA_W-1){1'b0}}, busy_q} :
        '0;

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
            rd_data_q <= '0;
        else if (rd_en_i)
            rd_data_q <= rd_mux;
        else
            rd_data_q <= '0;
    end

    // whole entry, flag and value, is the repeated unit
    wire [DATA_W-1:0] cur_entry = slot_q[slot_idx_q];
    wire              cur_delay = cur_entry[DELAY_FLAG_BIT];
    wire [VAL_W-1:0]  cur_val   = cur_entry[VAL_W-1:0];
    wire [REP_W-1:0]  cur_rep   = rep_field[slot_idx_q];

    // another pass while below count, or forever at seven
    wire more_pass = (loop_q == LOOP_FOREVER) || (pass_q < loop_q);
    wire [LOOP_W-1:0] pass_inc = (loop_q == LOOP_FOREVER)
                               ? pass_q : pass_q + LOOP_W'(1);

    always_comb
    begin
        state_d    = state_q;
        slot_idx_d = slot_idx_q;
        pass_d     = pass_q;
        play_req_d = 1'b0;
        seq_done_d = 1'b0;
        tmr_start  = 1'b0;
        cnt_clr    = 1'b0;
        cnt_inc    = 1'b0;
        case (state_q)
            SEQ_IDLE:
            begin
                // playback starts at the first slot
                if (go_wr)
                begin
                    state_d    = SEQ_CHECK;
                    slot_idx_d = '0;
                    pass_d     = '0;
                    cnt_clr    = 1'b1;
                end
            end
            SEQ_CHECK:
            begin
                if (cur_delay)
                begin
                    // delay entry idles value times 10 ms
                    tmr_start = 1'b1;
                    state_d   = SEQ_WAIT;
                end
                else if (cur_val != '0)
                begin
                    play_req_d = 1'b1;
                    state_d    = SEQ_PLAY;
                end
                else if (more_pass && slot_idx_q != '0)
                begin
                    // replay the sequence from slot one
                    slot_idx_d = '0;
                    pass_d     = pass_inc;
                    cnt_clr    = 1'b1;
                end
                else
                begin
                    // empty first slot, or zero entry with no passes left: sequence ends
                    state_d    = SEQ_IDLE;
                    seq_done_d = 1'b1;
                end
            end
            SEQ_PLAY:
            begin
                if (play_done_i)
                    state_d = SEQ_NEXT;
            end
            SEQ_WAIT:
            begin
                if (tmr_done)
                    state_d = SEQ_NEXT;
            end
            SEQ_NEXT:
            begin
                state_d = SEQ_CHECK;
                // replay until N extra plays are done
                if (!cnt_last)
                    cnt_inc = 1'b1;
                // advance only after the last play
                else if (slot_idx_q != LAST_SLOT)
                begin
                    slot_idx_d = slot_idx_q + SLOT_IDX_W'(1);
                    cnt_clr    = 1'b1;
                end
                else if (more_pass)
                begin
                    slot_idx_d = '0;
                    pass_d     = pass_inc;
                    cnt_clr    = 1'b1;
                end
                else
                begin
                    state_d    = SEQ_IDLE;
                    seq_done_d = 1'b1;
                    cnt_clr    = 1'b1;
                end
            end
            default:
            begin
                state_d = SEQ_IDLE;
            end
        endcase
        if (stop_rq)
        begin
            // trigger or go control ends any loop
            state_d    = SEQ_IDLE;
            play_req_d = 1'b0;
            seq_done_d = 1'b0;
            tmr_start  = 1'b0;
            cnt_clr    = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            state_q    <= SEQ_IDLE;
            slot_idx_q <= '0;
            pass_q     <= '0;
            play_req_q <= 1'b0;
            seq_done_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            slot_idx_q <= slot_idx_d;
            pass_q     <= pass_d;
            play_req_q <= play_req_d;
            seq_done_q <= seq_done_d;
        end
    end

    // status copies so every output leaves a flop
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            effect_id_q    <= '0;
            busy_q         <= 1'b0;
            delay_active_q <= 1'b0;
        end
        else
        begin
            if (play_req_d)
                effect_id_q <= cur_val;
            busy_q         <= (state_d != SEQ_IDLE);
            delay_active_q <= (state_d == SEQ_WAIT);
        end
    end

    // stop also cancels a running delay
    ssrc_delay_timer #(
        .UNIT_CYC (UNIT_CYC)
    ) u_delay (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .start_i    (tmr_start),
        .abort_i    (stop_rq),
        .units_i    (cur_val),
        .done_o     (tmr_done)
    );

    ssrc_play_counter u_plays (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .clr_i      (cnt_clr),
        .inc_i      (cnt_inc),
        .limit_i    (cur_rep),
        .last_o     (cnt_last)
    );

    assign rd_data_o      = rd_data_q;
    assign play_req_o     = play_req_q;
    assign effect_id_o    = effect_id_q;
    assign slot_idx_o     = slot_idx_q;
    assign delay_active_o = delay_active_q;
    assign busy_o         = busy_q;
    assign seq_done_o     = seq_done_q;
endmodule : ssrc_sequencer

// ### dv/ssrc_properties.sv
// port-level assertions for the slot repeat sequencer
module ssrc_properties #(
    parameter int UNIT_CYC = ssrc_pkg::DELAY_UNIT_CYC
) (
    input wire logic                            core_clk_i,
    input wire logic                            rstn_i,
    input wire logic [ssrc_pkg::ADDR_W-1:0]     addr_i,
    input wire logic [ssrc_pkg::DATA_W-1:0]     wr_data_i,
    input wire logic                            wr_en_i,
    input wire logic                            rd_en_i,
    input wire logic [ssrc_pkg::DATA_W-1:0]     rd_data_o,
    input wire logic                            stop_i,
    input wire logic                            play_done_i,
    input wire logic                            play_req_o,
    input wire logic [ssrc_pkg::VAL_W-1:0]      effect_id_o,
    input wire logic [ssrc_pkg::SLOT_IDX_W-1:0] slot_idx_o,
    input wire logic                            delay_active_o,
    input wire logic                            busy_o,
    input wire logic                            seq_done_o
);
    import ssrc_pkg::*;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    AST_RD_IDLE: assert property (!rd_en_i |=> rd_data_o == 8'h00)
        else $error("read data not zero outside a read");
    AST_LOWER_RW: assert property (
        (wr_en_i && addr_i == REP_LOWER_OFS) ##1 !wr_en_i
        ##1 (rd_en_i && addr_i == REP_LOWER_OFS)
        |=> rd_data_o == $past(wr_data_i, 3))
        else $error("lower repeat register lost its value");
    AST_UPPER_RW: assert property (
        (wr_en_i && addr_i == REP_UPPER_OFS) ##1 !wr_en_i
        ##1 (rd_en_i && addr_i == REP_UPPER_OFS)
        |=> rd_data_o == $past(wr_data_i, 3))
        else $error("upper repeat register lost its value");
    AST_GO_BUSY: assert property (wr_en_i && addr_i == CTRL_OFS
        && wr_data_i[CTRL_GO_BIT] && !stop_i && !busy_o |=> busy_o)
        else $error("start write did not raise busy");
    AST_FIRST_PLAY: assert property ($rose(busy_o)
        |-> ##[1:2] (play_req_o || delay_active_o || !busy_o))
        else $error("first slot not started after go");
    // engine may answer on the very next edge, so two quiet cycles
    AST_REQ_GAP: assert property (play_req_o |=> !play_req_o [*2])
        else $error("play request too soon after previous");
    AST_REQ_IDLE_DLY: assert property (play_req_o
        |-> busy_o && !delay_active_o)
        else $error("play request while idle or timing a delay");
    AST_SLOT_STEP: assert property (busy_o && $changed(slot_idx_o)
        |-> (slot_idx_o == $past(slot_idx_o) + 3'h1) || (slot_idx_o == 3'h0))
        else $error("slot index skipped a slot");
    AST_DONE_END: assert property (seq_done_o
        |-> !busy_o && $past(busy_o))
        else $error("done pulse not at end of busy");
    AST_STOP: assert property (stop_i && busy_o
        |=> !busy_o && !seq_done_o)
        else $error("stop did not abort at once");
endmodule : ssrc_properties

bind ssrc_sequencer ssrc_properties #(.UNIT_CYC(UNIT_CYC)) u_props (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .stop_i(stop_i), .play_done_i(play_done_i),
    .play_req_o(play_req_o), .effect_id_o(effect_id_o),
    .slot_idx_o(slot_idx_o), .delay_active_o(delay_active_o),
    .busy_o(busy_o), .seq_done_o(seq_done_o)
);

// ### dv/tb.sv
// self-checking bench for the slot repeat sequencer
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ssrc_pkg::*;
    logic                  core_clk_i = 1'b0;
    logic                  rstn_i = 1'b0;
    logic [ADDR_W-1:0]     addr_i = 8'h00;
    logic [DATA_W-1:0]     wr_data_i = 8'h00;
    logic                  wr_en_i = 1'b0;
    logic                  rd_en_i = 1'b0;
    logic                  stop_i = 1'b0;
    logic                  play_done_i = 1'b0;
    logic                  play_req_o, seq_done_o, delay_active_o, busy_o;
    logic [DATA_W-1:0]     rd_data_o, d, w;
    logic [VAL_W-1:0]      effect_id_o;
    logic [SLOT_IDX_W-1:0] slot_idx_o;
    logic [7:0]            slot [8];
    logic [7:0]            exp_q [$];
    logic [7:0]            got_q [$];
    logic [15:0]           reps;
    logic [7:0]            done_n = 8'h00;
    logic                  dly_q = 1'b0;
    logic [7:0]            dly_n = 8'h00;
    int                    miscompares = 0;
    int                    comparisons = 0;
    int                    lp;
    int                    seed = 32'hBB8B;

    initial
        forever #2.5 core_clk_i = ~core_clk_i;

    // short delay unit keeps timed waits to a few cycles
    localparam int UNIT = 4;
    ssrc_sequencer #(.UNIT_CYC(UNIT)) uut (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o), .stop_i(stop_i), .play_done_i(play_done_i),
        .play_req_o(play_req_o), .effect_id_o(effect_id_o),
        .slot_idx_o(slot_idx_o), .delay_active_o(delay_active_o),
        .busy_o(busy_o), .seq_done_o(seq_done_o)
    );

    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string n, input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    // each access leaves one idle cycle so strobes never re-assert at once
    task automatic wr(input logic [7:0] a, dat);
        addr_i <= a;
        wr_data_i <= dat;
        wr_en_i <= 1'b1;
        @(posedge core_clk_i);
        wr_en_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge core_clk_i);
        rd_en_i <= 1'b0;
        @(negedge core_clk_i);
        dat = rd_data_o;
        @(posedge core_clk_i);
    endtask : rd

    // playback engine stand-in, answers after 1 to 4 cycles
    initial
        forever
        begin
            @(negedge core_clk_i);
            if (play_req_o === 1'b1)
            begin
                repeat (1 + $unsigned($random(seed)) % 4)
                    @(posedge core_clk_i);
                play_done_i <= 1'b1;
                @(posedge core_clk_i);
                play_done_i <= 1'b0;
            end
        end

    always @(negedge core_clk_i)
    begin
        if (rstn_i === 1'b1)
        begin
            if (play_req_o === 1'b1)
                got_q.push_back({1'b0, effect_id_o});
            if (delay_active_o === 1'b1 && dly_q !== 1'b1)
                got_q.push_back({5'h10, slot_idx_o});
            if (seq_done_o === 1'b1)
                done_n++;
            // a stop cuts a delay short, so only normal ends are timed
            if (delay_active_o !== 1'b1 && dly_q === 1'b1
                && busy_o === 1'b1)
                chk("delay", dly_n,
                    8'(int'(slot[slot_idx_o][6:0]) * UNIT + 2));
        end
        dly_n = (delay_active_o === 1'b1) ? dly_n + 8'h01 : 8'h00;
        dly_q = delay_active_o;
    end

    function automatic void build();
        exp_q.delete();
        for (int p = 0; p <= lp; p++)
            for (int s = 0; s < 8; s++)
            begin
                if (slot[s] == 8'h00)
                    break;
                for (int r = 0; r <= int'(reps[2*s +: 2]); r++)
                    exp_q.push_back(slot[s][7] ? {5'h10, s[2:0]} : slot[s]);
            end
    endfunction : build

    task automatic run_seq();
        int e;
        logic [7:0] r;
        e = $unsigned($random(seed)) % 9;
        for (int s = 0; s < 8; s++)
        begin
            r = 8'($random(seed));
            slot[s] = (s == e) ? 8'h00 :
                r[3] ? {6'h20, r[1:0]} : {1'b0, r[6:0] | 7'h01};
            wr(SLOT_FIRST_OFS + 8'(s), slot[s]);
        end
        reps = 16'($random(seed));
        lp = $unsigned($random(seed)) % 3;
        wr(REP_LOWER_OFS, reps[7:0]);
        wr(REP_UPPER_OFS, reps[15:8]);
        wr(MAIN_LOOP_OFS, 8'(lp));
        build();
        got_q.delete();
        done_n = 8'h00;
        wr(CTRL_OFS, 8'h01);
        @(negedge core_clk_i);
        for (int i = 0; i < 3000 && busy_o !== 1'b0; i++)
            @(negedge core_clk_i);
        chk("end", {7'h00, busy_o}, 8'h00);
        @(posedge core_clk_i);
        chk("done", done_n, 8'h01);
        chk("plays", 8'(got_q.size()), 8'(exp_q.size()));
        foreach (exp_q[i])
            chk("entry", got_q[i], exp_q[i]);
    endtask : run_seq

    initial
    begin
        #300000;
        miscompares++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        for (int a = 8'h0C; a <= 8'h20; a++)
        begin
            rd(a[7:0], d);
            chk("reset", d, 8'h00);
        end
        for (int a = 8'h0D; a <= 8'h20; a++)
        begin
            w = 8'($random(seed));
            wr(a[7:0], w);
            rd(a[7:0], d);
            chk("reg", d, (a >= 8'h0F && a <= 8'h18) ? w :
                (a == 8'h19) ? (w & 8'h07) : 8'h00);
        end
        repeat (12)
            run_seq();
        wr(SLOT_FIRST_OFS, 8'h05);
        wr(MAIN_LOOP_OFS, 8'(LOOP_FOREVER));
        for (int m = 0; m < 3; m++)
        begin
            done_n = 8'h00;
            wr(CTRL_OFS, 8'h01);
            repeat (40) @(posedge core_clk_i);
            if (m == 0)
                wr(CTRL_OFS, 8'h00);
            else
            begin
                stop_i <= (m == 1);
                rstn_i <= (m != 2);
                repeat (2) @(posedge core_clk_i);
                stop_i <= 1'b0;
                rstn_i <= 1'b1;
            end
            repeat (4) @(posedge core_clk_i);
            rd(CTRL_OFS, d);
            chk("busy", d, 8'h00);
            chk("aborted", done_n, 8'h00);
            rd(MAIN_LOOP_OFS, d);
            chk("loop", d, (m == 2) ? 8'h00 : 8'h07);
        end
        end_of_test();
    end
endmodule : tb
